//--- logic/lamp_bus_params.svh
/*
 * Constants of the lamp bus node: timing, address ranges, command codes.
 * Assumes a 200 MHz system clock; included by bare name.
 */
// Functional notes
// R1: Every node sends and receives characters at 38.4K baud.
// R2: Characters are 11 bits: start, nine data bits, stop.
// R3: Data bits go onto the line least significant bit first.
// R4: Lamp 0 masters by default; lamp 1, then lamp 2, take over.
// R5: Data bit 8 high marks an address, low marks data.
// R6: Panels use addresses 0-15; lamps 16-56, switch value plus 16.
// R7: Master polls panel addresses 0 to 15 first, then lamp addresses.
// R8: Non-master never drives the bus until its own address arrives.
// R9: Master listens 1mS after each address, longer if traffic continues.
// R10: More than three silent lamp addresses restart polling at panel 0.
// R11: A polled panel transmits only when it has pending activity.
// R12: A lamp always replies after seeing its own address polled.
// R13: Lamp executes commands only after a selection value matching itself.
// R14: Panel opens with a selection value that has bit 7 clear.
// R15: A panel transmission is 2 to 10 bytes long.
// R16: Several commands in one slot go in ascending code order.
// R17: Code 01 carries a pan rate centred on 128, span 64.
// R18: Code 02 carries a tilt rate centred on 128, span 64.
// R19: Code 0A inverts lamp on/off each time it arrives.
// R20: Code 0B runs focus motor while the command keeps arriving.
// R21: Code 0C drives home and completes without repetition.
// R22: First reply byte within 1mS, gaps between reply bytes under 1mS.
// R23: Panel check byte is 8-bit sum of unmodified lamp address and commands.
// R24: Lamp reply is pan lo/hi, tilt lo/hi, status, sum check.
// R25: Drop characters with a low stop bit and frames failing the check.
`ifndef LAMP_BUS_PARAMS_SVH
`define LAMP_BUS_PARAMS_SVH

`define CLK_HZ 200000000
`define BAUD 38400
`define BIT_CYC_DEF (`CLK_HZ / `BAUD)
`define CYC_PER_US (`CLK_HZ / 1000000)
`define DEAD_US 1000
`define DEAD_CYC_DEF (`DEAD_US * `CYC_PER_US)
`define TAKEOVER_US 20000
`define TAKEOVER_CYC_DEF (`TAKEOVER_US * `CYC_PER_US)
`define HOLD_US 250000
`define HOLD_CYC_DEF (`HOLD_US * `CYC_PER_US)

`define CHAR_LAST_BIT 4'd10
`define SEL_BIT 7
`define PANEL_ADDR_MAX 8'h0f
`define LAMP_BASE 8'h10
`define LAMP_POLL_MAX 6'd56
`define MAX_MISS 2'd3
`define MASTER_SW_MAX 6'd2
`define FRAME_MIN 4'd2
`define FRAME_MAX 10
`define REPLY_LEN 3'd6
`define RATE_CENTRE 8'h80

`define CMD_PAN 8'h01
`define CMD_TILT 8'h02
`define CMD_LAMP 8'h0a
`define CMD_FOCUS 8'h0b
`define CMD_HOME 8'h0c
`define CMD_PAN_POS 8'h18
`define CMD_TILT_POS 8'h19

`endif

//--- logic/lamp_bus_pkg.sv
/*
 * Types of the lamp bus node: transmit sequencer states and state records.
 * Assumes lamp_bus_params.svh is on the include path.
 */
`include "lamp_bus_params.svh"

package lamp_bus_pkg;

    typedef enum logic [1:0] {
        T_IDLE  = 2'b00,
        T_REPLY = 2'b01,
        T_MADDR = 2'b10,
        T_MWAIT = 2'b11
    } tx_state_t;

    typedef struct packed {
        logic rx_act;
        logic [15:0] rx_tmr;
        logic [3:0] rx_bit;
        logic [8:0] rx_sh;
        logic rx_valid;
        logic [8:0] rx_char;
        logic tx_act;
        logic [15:0] tx_tmr;
        logic [3:0] tx_bit;
        logic [10:0] tx_sh;
        logic txd;
        logic [8:0] tx_held;
    } uart_st_t;

    typedef struct packed {
        tx_state_t ts;
        logic master;
        logic tx_en;
        logic tx_go;
        logic [8:0] tx_char;
        logic [2:0] rep_idx;
        logic [7:0] rep_sum;
        logic [5:0] poll;
        logic [1:0] miss;
        logic heard;
        logic [31:0] quiet;
        logic coll;
        logic sel_ok;
        logic ovf;
        logic [3:0] cnt;
        logic [7:0] sum;
        logic [7:0] last;
        logic [`FRAME_MAX-1:0][7:0] fbuf;
        logic exec;
        logic [3:0] idx;
        logic [3:0] iend;
        logic focus_seen;
        logic lamp_on;
        logic [7:0] pan_rate;
        logic [7:0] tilt_rate;
        logic focus;
        logic home;
        logic [31:0] hold;
    } node_st_t;

endpackage : lamp_bus_pkg

//--- logic/char_uart.sv
/*
 * Nine-bit character transmitter and receiver, 11-bit frames, LSB first.
 * Assumes rxd is synchronous to clk and idles high.
 */
`include "lamp_bus_params.svh"

module char_uart
    import lamp_bus_pkg::*;
#(
    parameter int BIT_CYC = `BIT_CYC_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Line
    input wire logic rxd,
    output logic txd,
    // Transmit request
    input wire logic tx_start,
    input wire logic [8:0] tx_char,
    output logic tx_busy,
    // Receive result
    output logic rx_busy,
    output logic rx_valid,
    output logic [8:0] rx_char
);

    localparam logic [15:0] BIT_C = 16'(BIT_CYC - 1);
    localparam logic [15:0] HALF_C = 16'(BIT_CYC / 2);

    generate
        if (BIT_CYC < 16 || BIT_CYC > 65535) begin : g_bad_bit
            $error("char_uart: BIT_CYC out of range");
        end
    endgenerate

    uart_st_t s_r;
    uart_st_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.rx_valid = 1'b0;
        // Receiver, mid-bit sampling
        if (!s_r.rx_act) begin
            if (!rxd) begin
                s_nxt.rx_act = 1'b1;
                s_nxt.rx_tmr = HALF_C;
                s_nxt.rx_bit = 4'd0;
            end
        end else if (s_r.rx_tmr != 16'h0000) begin
            s_nxt.rx_tmr = s_r.rx_tmr - 16'h0001;
        end else begin
            s_nxt.rx_tmr = BIT_C; // [R1]
            s_nxt.rx_bit = s_r.rx_bit + 4'd1;
            if (s_r.rx_bit == 4'd0) begin
                s_nxt.rx_act = !rxd;
            end else if (s_r.rx_bit == `CHAR_LAST_BIT) begin
                s_nxt.rx_act = 1'b0;
                s_nxt.rx_valid = rxd; // [R25]
                s_nxt.rx_char = s_r.rx_sh;
            end else begin
                s_nxt.rx_sh = {rxd, s_r.rx_sh[8:1]}; // [R3]
            end
        end
        // Transmitter
        if (!s_r.tx_act) begin
            if (tx_start) begin
                s_nxt.tx_act = 1'b1;
                s_nxt.tx_sh = {1'b1, tx_char, 1'b0}; // [R2]
                s_nxt.tx_held = tx_char;
                s_nxt.tx_bit = 4'd0;
                s_nxt.tx_tmr = BIT_C;
                s_nxt.txd = 1'b0;
            end
        end else if (s_r.tx_tmr != 16'h0000) begin
            s_nxt.tx_tmr = s_r.tx_tmr - 16'h0001;
        end else begin
            s_nxt.tx_tmr = BIT_C; // [R1]
            s_nxt.tx_sh = {1'b1, s_r.tx_sh[10:1]}; // [R3]
            s_nxt.txd = s_r.tx_sh[1];
            s_nxt.tx_bit = s_r.tx_bit + 4'd1;
            if (s_r.tx_bit == `CHAR_LAST_BIT) begin
                s_nxt.tx_act = 1'b0;
                s_nxt.txd = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.txd <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign txd = s_r.txd;
    assign tx_busy = s_r.tx_act;
    assign rx_busy = s_r.rx_act;
    assign rx_valid = s_r.rx_valid;
    assign rx_char = s_r.rx_char;

    AST_START_BIT: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
        tx_start && !s_r.tx_act |=> !s_r.txd && s_r.tx_act)
        else $error("start bit not sent");
    AST_LSB_FIRST: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
        s_r.tx_act && s_r.tx_bit == 4'd1 |-> s_r.txd == s_r.tx_held[0])
        else $error("first data bit is not the lsb");
    AST_STOP_HIGH: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
        s_r.tx_act && s_r.tx_bit == `CHAR_LAST_BIT |-> s_r.txd)
        else $error("stop bit not high");
    AST_BIT_TIME: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
        s_r.tx_act |-> s_r.tx_tmr <= BIT_C)
        else $error("bit timer exceeds bit period");
    AST_STOP_DISCARD: assert property (@(posedge clk) disable iff (!rst_n) // [R25]
        s_r.rx_valid |-> $past(rxd))
        else $error("character accepted with low stop bit");

endmodule : char_uart

//--- logic/lamp_bus_node.sv
/*
 * Lamp node of the polled multidrop lamp bus: bus mastering and polling,
 * panel frame reception and command decoding, six-byte lamp reply.
 * Assumes an external half-duplex line driver enabled by tx_en and a
 * static lamp address switch value on lamp_sw.
 */
`include "lamp_bus_params.svh"

module lamp_bus_node
    import lamp_bus_pkg::*;
#(
    parameter int BIT_CYC = `BIT_CYC_DEF,
    parameter int DEAD_CYC = `DEAD_CYC_DEF,
    parameter int TAKEOVER_CYC = `TAKEOVER_CYC_DEF,
    parameter int HOLD_CYC = `HOLD_CYC_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus line
    input wire logic rxd,
    output logic txd,
    output logic tx_en,
    // Configuration
    input wire logic [5:0] lamp_sw,
    // Lamp state
    input wire logic [11:0] pan_pos,
    input wire logic [11:0] tilt_pos,
    input wire logic pan_limit,
    input wire logic tilt_limit,
    input wire logic recording,
    input wire logic playing,
    input wire logic overheat,
    input wire logic home_done,
    // Lamp controls
    output logic is_master,
    output logic lamp_on,
    output logic [7:0] pan_rate,
    output logic [7:0] tilt_rate,
    output logic focus_run,
    output logic go_home
);

    localparam logic [31:0] DEAD_C = 32'(DEAD_CYC);
    localparam logic [31:0] HOLD_C = 32'(HOLD_CYC);
    localparam logic [31:0] TAKE_C = 32'(TAKEOVER_CYC);

    generate
        if (DEAD_CYC < 1 || TAKEOVER_CYC <= DEAD_CYC || HOLD_CYC < 1) begin : g_bad_time
            $error("lamp_bus_node: timing parameters out of range");
        end
    endgenerate

    node_st_t s_r;
    node_st_t s_nxt;

    logic rxd_g;
    logic tx_busy;
    logic rx_busy;
    logic rx_valid;
    logic [8:0] rx_char;
    logic [7:0] own;
    logic [31:0] take_lim;
    logic [7:0] reply_byte;
    logic [7:0] status_byte;
    logic frame_end;
    logic frame_ok;
    logic poll_lamp;

    assign rxd_g = s_r.tx_en ? 1'b1 : rxd;
    assign own = `LAMP_BASE + {2'b00, lamp_sw}; // [R6]
    assign take_lim = TAKE_C * (32'(lamp_sw) + 32'd1);
    assign poll_lamp = {2'b00, s_r.poll} > `PANEL_ADDR_MAX;
    assign status_byte = {1'b0, s_r.home, overheat, playing, recording, tilt_limit,
        pan_limit, s_r.lamp_on};

    char_uart #(
        .BIT_CYC(BIT_CYC)
    ) u_uart (
        .clk(clk),
        .rst_n(rst_n),
        .rxd(rxd_g),
        .txd(txd),
        .tx_start(s_r.tx_go),
        .tx_char(s_r.tx_char),
        .tx_busy(tx_busy),
        .rx_busy(rx_busy),
        .rx_valid(rx_valid),
        .rx_char(rx_char)
    );

    always_comb begin
        case (s_r.rep_idx)
            3'd0: reply_byte = pan_pos[7:0]; // [R24]
            3'd1: reply_byte = {4'h0, pan_pos[11:8]};
            3'd2: reply_byte = tilt_pos[7:0];
            3'd3: reply_byte = {4'h0, tilt_pos[11:8]};
            3'd4: reply_byte = status_byte;
            default: reply_byte = s_r.rep_sum;
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        frame_end = 1'b0;
        s_nxt.tx_go = 1'b0;
        // Bus silence timer
        if (rx_busy || s_r.tx_en) begin
            s_nxt.quiet = 32'h0000_0000;
        end else if (s_r.quiet != 32'hffff_ffff) begin
            s_nxt.quiet = s_r.quiet + 32'd1;
        end
        // Master takeover, lower switch values win first
        if (!s_r.master && lamp_sw <= `MASTER_SW_MAX && s_r.quiet >= take_lim) begin
            s_nxt.master = 1'b1; // [R4]
        end
        // Character reception
        if (rx_valid) begin
            if (s_r.ts == T_MWAIT) begin
                s_nxt.heard = 1'b1;
            end
            if (rx_char[8]) begin // [R5]
                frame_end = s_r.coll;
                s_nxt.coll = rx_char[7:0] <= `PANEL_ADDR_MAX; // [R6]
                s_nxt.cnt = 4'd0;
                s_nxt.ovf = 1'b0;
                s_nxt.sum = 8'h00;
                s_nxt.last = 8'h00;
                s_nxt.sel_ok = 1'b0;
                if (rx_char[7:0] == own && s_r.ts == T_IDLE && !s_r.master) begin
                    s_nxt.ts = T_REPLY; // [R12] [R8]
                    s_nxt.rep_idx = 3'd0;
                    s_nxt.rep_sum = own;
                end
            end else if (s_r.coll) begin
                if (s_r.cnt == 4'(`FRAME_MAX)) begin
                    s_nxt.ovf = 1'b1;
                end else begin
                    s_nxt.fbuf[s_r.cnt] = rx_char[7:0];
                    s_nxt.cnt = s_r.cnt + 4'd1;
                end
                s_nxt.sum = s_r.sum + s_r.last; // [R23]
                if (s_r.cnt == 4'd0) begin
                    s_nxt.last = rx_char[7:0] + `LAMP_BASE;
                    s_nxt.sel_ok = !rx_char[`SEL_BIT] && (rx_char[6:0] == {1'b0, lamp_sw});
                end else begin
                    s_nxt.last = rx_char[7:0];
                end
            end
        end else if (s_r.coll && s_r.cnt != 4'd0 && s_r.quiet >= DEAD_C) begin
            frame_end = 1'b1;
            s_nxt.coll = 1'b0;
        end
        // Frame is good when addressed here, sized right and summed right
        frame_ok = frame_end && s_r.sel_ok && !s_r.ovf && s_r.cnt >= `FRAME_MIN
            && s_r.last == s_r.sum; // [R13] [R23] [R25]
        // Home move runs until the drive reports arrival
        if (home_done) begin
            s_nxt.home = 1'b0; // [R21]
        end
        // Held commands lapse when no frame renews them
        if (s_r.hold != 32'h0000_0000) begin
            s_nxt.hold = s_r.hold - 32'd1;
        end else if (!s_r.exec) begin
            s_nxt.focus = 1'b0; // [R20]
            s_nxt.pan_rate = `RATE_CENTRE;
            s_nxt.tilt_rate = `RATE_CENTRE;
        end
        // Command walker over the stored frame
        if (s_r.exec) begin
            if (s_r.idx >= s_r.iend) begin
                s_nxt.exec = 1'b0;
                s_nxt.focus = s_r.focus_seen; // [R20]
                s_nxt.hold = HOLD_C;
            end else begin
                s_nxt.idx = s_r.idx + 4'd1;
                case (s_r.fbuf[s_r.idx])
                    `CMD_PAN: begin
                        s_nxt.pan_rate = s_r.fbuf[s_r.idx + 4'd1]; // [R17]
                        s_nxt.idx = s_r.idx + 4'd2;
                    end
                    `CMD_TILT: begin
                        s_nxt.tilt_rate = s_r.fbuf[s_r.idx + 4'd1]; // [R18]
                        s_nxt.idx = s_r.idx + 4'd2;
                    end
                    `CMD_LAMP: begin
                        s_nxt.lamp_on = !s_r.lamp_on; // [R19]
                    end
                    `CMD_FOCUS: begin
                        s_nxt.focus_seen = 1'b1; // [R20]
                    end
                    `CMD_HOME: begin
                        s_nxt.home = 1'b1; // [R21]
                    end
                    `CMD_PAN_POS, `CMD_TILT_POS: begin
                        s_nxt.idx = s_r.idx + 4'd3;
                    end
                    default: begin
                        s_nxt.idx = s_r.idx + 4'd1;
                    end
                endcase
            end
        end
        if (frame_ok) begin
            s_nxt.exec = 1'b1;
            s_nxt.idx = 4'd1;
            s_nxt.iend = s_r.cnt - 4'd1;
            s_nxt.focus_seen = 1'b0;
        end
        // Transmit sequencer
        case (s_r.ts)
            T_IDLE: begin
                if (s_r.master && !tx_busy) begin
                    s_nxt.ts = T_MADDR;
                    s_nxt.tx_char = {1'b1, 2'b00, s_r.poll}; // [R5] [R7]
                    s_nxt.tx_go = 1'b1;
                    s_nxt.heard = 1'b0;
                end
            end
            T_MADDR: begin
                if (!tx_busy && !s_r.tx_go) begin
                    if ({2'b00, s_r.poll} == own) begin
                        s_nxt.ts = T_REPLY; // [R12]
                        s_nxt.rep_idx = 3'd0;
                        s_nxt.rep_sum = own;
                        s_nxt.heard = 1'b1;
                    end else begin
                        s_nxt.ts = T_MWAIT;
                    end
                end
            end
            T_REPLY: begin
                if (!tx_busy && !s_r.tx_go) begin
                    if (s_r.rep_idx == `REPLY_LEN) begin
                        s_nxt.ts = s_r.master ? T_MWAIT : T_IDLE;
                    end else begin
                        s_nxt.tx_char = {1'b0, reply_byte}; // [R22] [R24]
                        s_nxt.tx_go = 1'b1;
                        s_nxt.rep_idx = s_r.rep_idx + 3'd1;
                        s_nxt.rep_sum = s_r.rep_sum + reply_byte;
                    end
                end
            end
            T_MWAIT: begin
                if (s_r.quiet >= DEAD_C && !rx_busy && !rx_valid) begin // [R9]
                    s_nxt.ts = T_IDLE;
                    if (poll_lamp && !s_r.heard && s_r.miss == `MAX_MISS) begin
                        s_nxt.poll = 6'd0; // [R10]
                        s_nxt.miss = 2'd0;
                    end else if (s_r.poll == `LAMP_POLL_MAX) begin
                        s_nxt.poll = 6'd0;
                        s_nxt.miss = 2'd0;
                    end else begin
                        s_nxt.poll = s_r.poll + 6'd1; // [R7]
                        s_nxt.miss = (poll_lamp && !s_r.heard) ? s_r.miss + 2'd1 : 2'd0;
                    end
                end
            end
            default: begin
                s_nxt.ts = T_IDLE;
            end
        endcase
        s_nxt.tx_en = (s_nxt.ts == T_MADDR) || (s_nxt.ts == T_REPLY); // [R8]
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.pan_rate <= `RATE_CENTRE;
            s_r.tilt_rate <= `RATE_CENTRE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tx_en = s_r.tx_en;
    assign is_master = s_r.master;
    assign lamp_on = s_r.lamp_on;
    assign pan_rate = s_r.pan_rate;
    assign tilt_rate = s_r.tilt_rate;
    assign focus_run = s_r.focus;
    assign go_home = s_r.home;

    AST_NO_DRIVE: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
        s_r.tx_en |-> (s_r.master || s_r.ts == T_REPLY))
        else $error("bus driven without mastership or own poll");
    AST_REPLY_START: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
        rx_valid && rx_char == {1'b1, own} && s_r.ts == T_IDLE && !s_r.master
        |=> s_r.ts == T_REPLY ##1 s_r.tx_go)
        else $error("no reply started after own address");
    AST_REPLY_SUM: assert property (@(posedge clk) disable iff (!rst_n) // [R24]
        s_r.tx_go && s_r.ts == T_REPLY && s_r.rep_idx == `REPLY_LEN
        |-> s_r.tx_char == {1'b0, $past(s_r.rep_sum)})
        else $error("sixth reply byte is not the running sum");
    AST_ADDR_CHAR: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
        s_r.tx_go |-> s_r.tx_char[8] == (s_r.ts == T_MADDR))
        else $error("address flag wrong on sent character");
    AST_TOGGLE: assert property (@(posedge clk) disable iff (!rst_n) // [R19]
        s_r.exec && s_r.idx < s_r.iend && s_r.fbuf[s_r.idx] == `CMD_LAMP
        |=> s_r.lamp_on != $past(s_r.lamp_on))
        else $error("lamp toggle not applied");
    AST_DROP_BAD: assert property (@(posedge clk) disable iff (!rst_n) // [R25]
        frame_end && s_r.last != s_r.sum |=> !s_r.exec)
        else $error("frame with bad check executed");
    AST_EXEC_SEL: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
        frame_end && !s_r.sel_ok |=> !s_r.exec)
        else $error("frame for another lamp executed");
    AST_HOME_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // [R21]
        s_r.home && !home_done |=> s_r.home)
        else $error("home move dropped before arrival");
    AST_MISS_RESTART: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
        s_r.ts == T_MWAIT && s_r.quiet >= DEAD_C && !rx_busy && !rx_valid && poll_lamp
        && !s_r.heard && s_r.miss == `MAX_MISS |=> s_r.poll == 6'd0)
        else $error("polling not restarted after silent lamps");
    AST_DEAD_TIME: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
        s_r.ts == T_MWAIT ##1 s_r.ts != T_MWAIT |-> $past(s_r.quiet) >= DEAD_C)
        else $error("next address sent inside dead time");
    AST_POLL_STEP: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
        s_r.ts == T_MWAIT ##1 s_r.ts == T_IDLE
        |-> s_r.poll == 6'd0 || s_r.poll == $past(s_r.poll) + 6'd1)
        else $error("poll address skipped");
    AST_MASTER_SW: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
        s_r.master |-> lamp_sw <= `MASTER_SW_MAX)
        else $error("lamp above switch 2 became master");
    AST_TAKEOVER: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
        !s_r.master && lamp_sw <= `MASTER_SW_MAX && s_r.quiet >= take_lim
        |=> s_r.master)
        else $error("master not taken after bus quiet");
    AST_IDLE_QUIET: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
        s_r.ts == T_IDLE && !s_r.master |-> !s_r.tx_en)
        else $error("idle lamp drives the bus");
    AST_REPLY_GAP: assert property (@(posedge clk) disable iff (!rst_n) // [R22]
        s_r.ts == T_REPLY && !tx_busy && !s_r.tx_go && s_r.rep_idx != `REPLY_LEN
        |=> s_r.tx_go)
        else $error("reply byte not sent back to back");
    AST_FRAME_EXEC: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
        frame_ok |=> s_r.exec)
        else $error("accepted frame not executed");
    AST_PAN_TAKE: assert property (@(posedge clk) disable iff (!rst_n) // [R17]
        s_r.exec && s_r.idx < s_r.iend && s_r.fbuf[s_r.idx] == `CMD_PAN
        |=> s_r.pan_rate == $past(s_r.fbuf[s_r.idx + 4'd1]))
        else $error("pan rate not taken");
    AST_HOME_SET: assert property (@(posedge clk) disable iff (!rst_n) // [R21]
        s_r.exec && s_r.idx < s_r.iend && s_r.fbuf[s_r.idx] == `CMD_HOME
        |=> s_r.home)
        else $error("home command not applied");
    AST_HOLD_LAPSE: assert property (@(posedge clk) disable iff (!rst_n) // [R20]
        s_r.hold == 32'h0000_0000 && !s_r.exec
        |=> !s_r.focus && s_r.pan_rate == `RATE_CENTRE
        && s_r.tilt_rate == `RATE_CENTRE)
        else $error("held commands did not lapse");

endmodule : lamp_bus_node

//--- sim/lamp_bus_panel.sv
/*
 * Panel side of the lamp bus: sends 9-bit characters on rxd, reads lamp characters from txd.
 * Assumes the bench clock and the node's bit time in BIT_CYC.
 */
module lamp_bus_panel #(
    parameter int BIT_CYC = 16
) (
    // Clock
    input wire logic clk,
    // Bus line
    input wire logic txd,
    input wire logic tx_en,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle line stays at the terminated high level
    initial rxd = 1'b1;

    task automatic send(input logic [8:0] c);
        logic [10:0] f;
        f = {1'b1, c, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge clk);
            rxd <= f[i];
            repeat (BIT_CYC - 1) @(posedge clk);
        end
    endtask : send

    task automatic get(output logic [8:0] c, output logic stop, output int wait_cyc);
        wait_cyc = 0;
        @(posedge clk);
        while (!(tx_en === 1'b1 && txd === 1'b0)) begin
            wait_cyc++;
            @(posedge clk);
        end
        repeat (BIT_CYC / 2) @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            c[i] = txd;
        end
        repeat (BIT_CYC) @(posedge clk);
        stop = txd;
    endtask : get
endmodule : lamp_bus_panel

//--- sim/test_lamp_bus_node.sv
/*
 * Bench of the lamp bus node: panel frames, command decode, lamp reply.
 * Assumes shortened bit and dead times; switch value 5, then 0 to take mastership.
 */
module test_lamp_bus_node;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int BIT = 16;
    localparam int DEAD = 400;
    logic clk, rst_n, rxd, txd, tx_en, is_master, lamp_on, focus_run, go_home;
    logic [5:0] lamp_sw;
    logic [5:0] st;
    logic [11:0] pan_pos, tilt_pos;
    logic [7:0] pan_rate, tilt_rate;
    int err_total, checked, cyc;

    lamp_bus_node #(.BIT_CYC(BIT), .DEAD_CYC(DEAD), .TAKEOVER_CYC(2000), .HOLD_CYC(20000))
    u_lamp_bus_node (.clk(clk), .rst_n(rst_n), .rxd(rxd), .txd(txd), .tx_en(tx_en),
        .lamp_sw(lamp_sw), .pan_pos(pan_pos), .tilt_pos(tilt_pos), .pan_limit(st[0]),
        .tilt_limit(st[1]), .recording(st[2]), .playing(st[3]), .overheat(st[4]),
        .home_done(st[5]), .is_master(is_master), .lamp_on(lamp_on), .pan_rate(pan_rate),
        .tilt_rate(tilt_rate), .focus_run(focus_run), .go_home(go_home));
    lamp_bus_panel #(.BIT_CYC(BIT)) u_lamp_bus_panel (.clk(clk), .txd(txd), .tx_en(tx_en),
        .rxd(rxd));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    // Panel slot: address, selection, commands, check; then bus quiet ends it
    task automatic frame(input logic [8:0] q[$]);
        foreach (q[i]) u_lamp_bus_panel.send(q[i]);
        repeat (DEAD + 50) @(posedge clk);
    endtask : frame

    task automatic t_select();
        frame('{9'h100, 9'h005, 9'h00a, 9'h01f});
        check("lamp_on", lamp_on, 1);
        frame('{9'h101, 9'h003, 9'h00a, 9'h01d});
        check("lamp_on other lamp", lamp_on, 1);
        frame('{9'h102, 9'h005, 9'h00a, 9'h020});
        check("lamp_on bad check", lamp_on, 1);
        check("never master", is_master, 0);
        $display("done select");
    endtask : t_select

    task automatic t_cmds();
        frame('{9'h101, 9'h005, 9'h001, 9'h0a0, 9'h002, 9'h040, 9'h00b, 9'h00c, 9'h00f});
        check("pan_rate", pan_rate, 8'ha0);
        check("tilt_rate", tilt_rate, 8'h40);
        check("focus_run", focus_run, 1);
        check("go_home", go_home, 1);
        frame('{9'h103, 9'h005, 9'h001, 9'h080, 9'h096});
        check("focus stops", focus_run, 0);
        check("pan centred", pan_rate, 8'h80);
        check("home kept", go_home, 1);
        @(posedge clk);
        st[5] <= 1'b1;
        @(posedge clk);
        st[5] <= 1'b0;
        repeat (3) @(posedge clk);
        check("home done", go_home, 0);
        $display("done commands");
    endtask : t_cmds

    task automatic t_reply();
        logic [7:0] e[6];
        logic [8:0] c;
        logic stop;
        int w;
        @(posedge clk);
        pan_pos <= 12'habc;
        tilt_pos <= 12'h123;
        st[4:0] <= 5'b10001;
        repeat (2) @(posedge clk);
        e = '{8'hbc, 8'h0a, 8'h23, 8'h01, {3'b001, 4'b0001, 1'b1}, 8'h00};
        e[5] = 8'h15;
        for (int i = 0; i < 5; i++) e[5] = e[5] + e[i];
        u_lamp_bus_panel.send(9'h115);
        for (int i = 0; i < 6; i++) begin
            u_lamp_bus_panel.get(c, stop, w);
            check("reply byte", c, {1'b0, e[i]});
            check("stop bit", stop, 1);
            check("reply gap", (w < DEAD), 1);
        end
        $display("done reply");
    endtask : t_reply

    task automatic t_master();
        logic [8:0] c;
        logic stop;
        int w;
        @(posedge clk);
        rst_n <= 1'b0;
        lamp_sw <= 6'h00;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (1000) @(posedge clk);
        check("master early", is_master, 0);
        u_lamp_bus_panel.get(c, stop, w);
        check("master", is_master, 1);
        check("poll 0", c, 9'h100);
        u_lamp_bus_panel.get(c, stop, w);
        check("poll 1", c, 9'h101);
        check("dead time", (w >= DEAD), 1);
        check("poll stop bit", stop, 1);
        $display("done master");
    endtask : t_master

    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            print_verdict();
        end
    end

    initial begin
        rst_n = 1'b0;
        lamp_sw = 6'h05;
        st = 6'h00;
        pan_pos = 12'h800;
        tilt_pos = 12'h800;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_select();
        t_cmds();
        t_reply();
        t_master();
        print_verdict();
    end
endmodule : test_lamp_bus_node
